// *** design/bsttap_consts.vh ***
`ifndef BSTTAP_CONSTS_VH
`define BSTTAP_CONSTS_VH

// Register widths
`define BSTTAP_IR_W          8
`define BSTTAP_CHAIN_W       18
`define BSTTAP_CTRL_W        2

// Reset and capture values
`define BSTTAP_IR_RESET      8'hFF
`define BSTTAP_IR_CAPTURE    8'h81
`define BSTTAP_CTRL_RESET    2'h2
`define BSTTAP_BYPASS_CAP    1'h0

// Opcodes, bit 7 dropped before compare
`define BSTTAP_OP_EXTEST     7'h00
`define BSTTAP_OP_SAMPLE     7'h02
`define BSTTAP_OP_INTEST     7'h03
`define BSTTAP_OP_HIGHZ      7'h06
`define BSTTAP_OP_CLAMP      7'h07
`define BSTTAP_OP_RUNT       7'h09
`define BSTTAP_OP_READBN     7'h0A
`define BSTTAP_OP_READBT     7'h0B
`define BSTTAP_OP_CELLTST    7'h0C
`define BSTTAP_OP_TOPHIP     7'h0D
`define BSTTAP_OP_SCANCN     7'h0E
`define BSTTAP_OP_SCANCT     7'h0F

// Data register selection codes
`define BSTTAP_SEL_BYPASS    2'h0
`define BSTTAP_SEL_CHAIN     2'h1
`define BSTTAP_SEL_CTRL      2'h2

`endif

// *** design/bsttap_sync.v ***
`timescale 1ns/1ps
module bsttap_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_clk,
  input  wire             i_reset,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;

  // Two-flop synchroniser; first stage feeds only the second
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_reg <= {WIDTH{1'b0}};
      o_sync   <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule // bsttap_sync

// *** design/bsttap_controller.v ***
// Functional notes
// - Test inputs sampled on test clock rise; test outputs change on its fall.
// - Sixteen-state machine stepped by mode select at each rising test clock.
// - Reset state holds test logic idle so normal buffering is untouched.
// - Mode select held high reaches reset state within five clocks.
// - Instruction register set to all ones in reset, selecting bypass.
// - Boundary control register loaded with binary 10 on reset.
// - Instruction-selected run-test operation runs only while in idle.
// - Both scan-select states do nothing and leave after one clock.
// - Data capture loads the selected chain or bypass register on the exiting rise; control keeps its contents.
// - Shift entry puts register on scan path; first fall drives its LSB.
// - Shifting starts on first rise after entry, ends on exiting rise.
// - First fall after entering exit-one floats the serial output.
// - Exit-two states may return to shift without recapture; pauses keep contents.
// - Data update latches selected register on fall after update entry, except the chain under readback.
// - Instruction capture loads fixed 10000001 on exiting rise.
// - Instruction update latches new opcode on fall after entry.
// - Each register except bypass has shift stage plus output latch.
// - Eight-bit instruction, bit 7 ignored, no parity check.
// - Unimplemented opcodes behave as bypass.
// - Data registers: 18-bit chain, 2-bit control, 1-bit bypass.
// - Instruction sets mode, operation, selected register, capture source.
// - Bypass stage captures zero during data capture.
`timescale 1ns/1ps
`include "bsttap_consts.vh"
module bsttap_controller #(
  parameter CHAIN_W = `BSTTAP_CHAIN_W
) (
  input  wire               i_clk,
  input  wire               i_reset,
  input  wire               i_tck,
  input  wire               i_tms,
  input  wire               i_tdi,
  input  wire [CHAIN_W-1:0] i_pin_sample,
  output reg                o_tdo,
  output reg                o_tdo_oe_n,
  output reg  [CHAIN_W-1:0] o_chain_latch,
  output reg  [1:0]         o_test_control,
  output reg  [7:0]         o_instruction,
  output reg                o_test_mode,
  output reg                o_outputs_highz,
  output reg                o_run_test,
  output reg  [15:0]        o_tap_state
);

  // One-hot controller states
  localparam [15:0] ST_RESET  = 16'h0001;
  localparam [15:0] ST_IDLE   = 16'h0002;
  localparam [15:0] ST_SEL_DR = 16'h0004;
  localparam [15:0] ST_CAP_DR = 16'h0008;
  localparam [15:0] ST_SH_DR  = 16'h0010;
  localparam [15:0] ST_EX1_DR = 16'h0020;
  localparam [15:0] ST_PA_DR  = 16'h0040;
  localparam [15:0] ST_EX2_DR = 16'h0080;
  localparam [15:0] ST_UP_DR  = 16'h0100;
  localparam [15:0] ST_SEL_IR = 16'h0200;
  localparam [15:0] ST_CAP_IR = 16'h0400;
  localparam [15:0] ST_SH_IR  = 16'h0800;
  localparam [15:0] ST_EX1_IR = 16'h1000;
  localparam [15:0] ST_PA_IR  = 16'h2000;
  localparam [15:0] ST_EX2_IR = 16'h4000;
  localparam [15:0] ST_UP_IR  = 16'h8000;

  // Next state from current state and mode select
  function [15:0] bsttap_next;
    input [15:0] st;
    input        tms;
    begin
      case (st)
        ST_RESET:  bsttap_next = tms ? ST_RESET  : ST_IDLE;
        ST_IDLE:   bsttap_next = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: bsttap_next = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: bsttap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  bsttap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: bsttap_next = tms ? ST_UP_DR  : ST_PA_DR;
        ST_PA_DR:  bsttap_next = tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: bsttap_next = tms ? ST_UP_DR  : ST_SH_DR;
        ST_UP_DR:  bsttap_next = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: bsttap_next = tms ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: bsttap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  bsttap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: bsttap_next = tms ? ST_UP_IR  : ST_PA_IR;
        ST_PA_IR:  bsttap_next = tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: bsttap_next = tms ? ST_UP_IR  : ST_SH_IR;
        ST_UP_IR:  bsttap_next = tms ? ST_SEL_DR : ST_IDLE;
        default:   bsttap_next = ST_RESET;
      endcase
    end
  endfunction

  // True in either shift state; the serial output is driven only there
  function bsttap_is_shift;
    input [15:0] st;
    begin
      bsttap_is_shift = (st == ST_SH_IR) || (st == ST_SH_DR);
    end
  endfunction

  // Opcode decode: {highz, runt, readback, test mode, select[1:0]}
  function [5:0] bsttap_decode;
    input [7:0] op;
    reg   [6:0] code;
    begin
      code = op[6:0];
      if (code == `BSTTAP_OP_EXTEST || code == `BSTTAP_OP_INTEST) begin
        bsttap_decode = {4'h1, `BSTTAP_SEL_CHAIN};
      end else if (code == `BSTTAP_OP_SAMPLE || code == `BSTTAP_OP_CELLTST) begin
        bsttap_decode = {4'h0, `BSTTAP_SEL_CHAIN};
      end else if (code == `BSTTAP_OP_HIGHZ) begin
        bsttap_decode = {4'h9, `BSTTAP_SEL_BYPASS};
      end else if (code == `BSTTAP_OP_CLAMP || code == `BSTTAP_OP_TOPHIP) begin
        bsttap_decode = {4'h1, `BSTTAP_SEL_BYPASS};
      end else if (code == `BSTTAP_OP_RUNT) begin
        bsttap_decode = {4'h5, `BSTTAP_SEL_BYPASS};
      end else if (code == `BSTTAP_OP_READBN) begin
        bsttap_decode = {4'h2, `BSTTAP_SEL_CHAIN};
      end else if (code == `BSTTAP_OP_READBT) begin
        bsttap_decode = {4'h3, `BSTTAP_SEL_CHAIN};
      end else if (code == `BSTTAP_OP_SCANCN) begin
        bsttap_decode = {4'h0, `BSTTAP_SEL_CTRL};
      end else if (code == `BSTTAP_OP_SCANCT) begin
        bsttap_decode = {4'h1, `BSTTAP_SEL_CTRL};
      end else begin
        bsttap_decode = {4'h0, `BSTTAP_SEL_BYPASS};
      end
    end
  endfunction

  // Synchronised pins
  wire [CHAIN_W+2:0] sync_bus;
  wire               tck_sync;
  wire               tms_sync;
  wire               tdi_sync;
  wire [CHAIN_W-1:0] pins_sync;

  bsttap_sync #(
    .WIDTH (CHAIN_W + 3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({i_pin_sample, i_tdi, i_tms, i_tck}),
    .o_sync  (sync_bus)
  );

  assign tck_sync  = sync_bus[0];
  assign tms_sync  = sync_bus[1];
  assign tdi_sync  = sync_bus[2];
  assign pins_sync = sync_bus[CHAIN_W+2:3];

  // Test clock edge finder on the system clock
  // Edges are held off until the synchroniser carries the real pin level,
  // so a test clock parked high at reset release gives no false rise
  reg  [1:0] settle_reg;
  reg        tck_prev_reg;
  wire       edges_armed;
  wire       tck_rise;
  wire       tck_fall;

  always @(posedge i_clk) begin
    if (i_reset) begin
      settle_reg   <= 2'h0;
      tck_prev_reg <= 1'b0;
    end else begin
      if (!edges_armed) begin
        settle_reg <= settle_reg + 2'h1;
      end
      tck_prev_reg <= tck_sync;
    end
  end

  assign edges_armed = (settle_reg == 2'h3);
  assign tck_rise    = edges_armed & tck_sync & ~tck_prev_reg;
  assign tck_fall    = edges_armed & ~tck_sync & tck_prev_reg;

  // Controller state and shift stages
  reg  [15:0]        state_reg;
  reg  [7:0]         ir_shift_reg;
  reg  [CHAIN_W-1:0] chain_shift_reg;
  reg  [1:0]         ctrl_shift_reg;
  reg                bypass_reg;
  wire [15:0]        state_next;
  wire [7:0]         instr_eff;
  wire [5:0]         dec;
  wire [1:0]         sel;
  wire               readback;
  wire               dec_test;
  wire               dec_runt;
  wire               dec_highz;
  wire               sel_chain;
  wire               sel_ctrl;
  wire               in_shift;

  assign state_next = bsttap_next(state_reg, tms_sync);
  // In update-IR the fresh opcode is decoded from the shift stage, so the
  // mode change lands on the same fall that latches it
  assign instr_eff  = (state_reg == ST_UP_IR) ? ir_shift_reg : o_instruction;
  assign dec        = bsttap_decode(instr_eff);
  assign sel        = dec[1:0];
  assign readback   = dec[3];
  assign dec_test   = dec[2];
  assign dec_runt   = dec[4];
  assign dec_highz  = dec[5];

  // Register selection flags and shift-state flag
  assign sel_chain  = (sel == `BSTTAP_SEL_CHAIN);
  assign sel_ctrl   = (sel == `BSTTAP_SEL_CTRL);
  assign in_shift   = bsttap_is_shift(state_reg);

  // Rising-edge work: step state, reset reload, capture, shift; other states hold
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_reg       <= ST_RESET;
      ir_shift_reg    <= `BSTTAP_IR_RESET;
      chain_shift_reg <= {CHAIN_W{1'b0}};
      ctrl_shift_reg  <= `BSTTAP_CTRL_RESET;
      bypass_reg      <= 1'b0;
    end else if (tck_rise) begin
      state_reg <= state_next;
      case (state_reg)
        ST_RESET: begin
          ir_shift_reg   <= `BSTTAP_IR_RESET;
          ctrl_shift_reg <= `BSTTAP_CTRL_RESET;
        end
        ST_CAP_DR: begin
          if (sel == `BSTTAP_SEL_CHAIN) begin
            // Readback instructions return the latches, others the pins
            chain_shift_reg <= readback ? o_chain_latch : pins_sync;
          end else if (sel == `BSTTAP_SEL_BYPASS) begin
            bypass_reg <= `BSTTAP_BYPASS_CAP;
          end else begin
            // Control stage keeps its contents through data capture
            ctrl_shift_reg <= ctrl_shift_reg;
          end
        end
        ST_SH_DR: begin
          if (sel == `BSTTAP_SEL_CHAIN) begin
            chain_shift_reg <= {tdi_sync, chain_shift_reg[CHAIN_W-1:1]};
          end else if (sel == `BSTTAP_SEL_CTRL) begin
            ctrl_shift_reg <= {tdi_sync, ctrl_shift_reg[1]};
          end else begin
            bypass_reg <= tdi_sync;
          end
        end
        ST_CAP_IR: begin
          ir_shift_reg <= `BSTTAP_IR_CAPTURE;
        end
        ST_SH_IR: begin
          ir_shift_reg <= {tdi_sync, ir_shift_reg[7:1]};
        end
        ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR: begin
          // Exit and pause keep partial contents for a later resume
          chain_shift_reg <= chain_shift_reg;
          ctrl_shift_reg  <= ctrl_shift_reg;
          bypass_reg      <= bypass_reg;
          ir_shift_reg    <= ir_shift_reg;
        end
        default: begin
          ir_shift_reg <= ir_shift_reg;
        end
      endcase
    end
  end

  // Serial output value for the present shift state
  reg tdo_next;

  always @* begin
    tdo_next = o_tdo;
    if (state_reg == ST_SH_IR) begin
      tdo_next = ir_shift_reg[0];
    end else if (state_reg == ST_SH_DR) begin
      if (sel == `BSTTAP_SEL_CHAIN) begin
        tdo_next = chain_shift_reg[0];
      end else if (sel == `BSTTAP_SEL_CTRL) begin
        tdo_next = ctrl_shift_reg[0];
      end else begin
        tdo_next = bypass_reg;
      end
    end
  end

  // Latch next values, picked up by the falling-edge process below
  // Reset and the update states never coincide, so one chain suffices
  reg [7:0]         instr_next;
  reg [CHAIN_W-1:0] chain_latch_next;
  reg [1:0]         ctrl_latch_next;

  always @* begin
    instr_next       = o_instruction;
    chain_latch_next = o_chain_latch;
    ctrl_latch_next  = o_test_control;
    if (state_reg == ST_RESET) begin
      instr_next      = `BSTTAP_IR_RESET;
      ctrl_latch_next = `BSTTAP_CTRL_RESET;
    end else if (state_reg == ST_UP_IR) begin
      instr_next = ir_shift_reg;
    end else if (state_reg == ST_UP_DR) begin
      // Readback instructions leave the chain latches alone
      if (sel_chain && !readback) begin
        chain_latch_next = chain_shift_reg;
      end
      if (sel_ctrl) begin
        ctrl_latch_next = ctrl_shift_reg;
      end
    end
  end

  // Falling-edge work: drive outputs and update latches
  // Outputs wait for the fall so the far end sees half a cycle of setup
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_tdo           <= 1'b1;
      o_tdo_oe_n      <= 1'b1;
      o_chain_latch   <= {CHAIN_W{1'b0}};
      o_test_control  <= `BSTTAP_CTRL_RESET;
      o_instruction   <= `BSTTAP_IR_RESET;
      o_test_mode     <= 1'b0;
      o_outputs_highz <= 1'b0;
      o_run_test      <= 1'b0;
      o_tap_state     <= ST_RESET;
    end else if (tck_fall) begin
      o_tap_state <= state_reg;
      o_tdo       <= tdo_next;
      // Driven only in the shift states, floated from exit-one onward
      o_tdo_oe_n  <= ~in_shift;
      o_instruction  <= instr_next;
      o_chain_latch  <= chain_latch_next;
      o_test_control <= ctrl_latch_next;
      if (state_reg == ST_RESET) begin
        o_test_mode     <= 1'b0;
        o_outputs_highz <= 1'b0;
        o_run_test      <= 1'b0;
      end else begin
        // Mode follows the effective instruction, on the update fall itself
        o_test_mode     <= dec_test;
        o_outputs_highz <= dec_highz;
        // Idle is reachable from reset and both update states; operations run only there
        o_run_test      <= dec_runt && (state_reg == ST_IDLE);
      end
    end
  end

endmodule // bsttap_controller

// *** verification/bsttap_monitor.sv ***
`timescale 1ns/1ps
module bsttap_monitor #(
  parameter CHAIN_W = 18
) (
  input wire logic               i_clk,
  input wire logic               i_reset,
  input wire logic               i_tck,
  input wire logic               o_tdo,
  input wire logic               o_tdo_oe_n,
  input wire logic [CHAIN_W-1:0] o_chain_latch,
  input wire logic [1:0]         o_test_control,
  input wire logic [7:0]         o_instruction,
  input wire logic               o_test_mode,
  input wire logic               o_outputs_highz,
  input wire logic               o_run_test,
  input wire logic [15:0]        o_tap_state
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Reset itself must land the documented values one clock later
  a_reset_vals: assert property (disable iff (1'b0)
    i_reset |=> o_tap_state == 16'h0001 && o_instruction == 8'hFF && o_test_control == 2'h2)
    else $error("reset values wrong");
  a_state_onehot: assert property ($onehot(o_tap_state))
    else $error("state not one-hot");
  a_reset_keeps: assert property (o_tap_state[0] ##1 o_tap_state[0]
    |-> o_instruction == 8'hFF && o_test_control == 2'h2) else $error("reset state values");
  a_tdo_enable: assert property (o_tdo_oe_n == !(o_tap_state[4] || o_tap_state[11]))
    else $error("tdo enable outside shift");
  // Outputs may only move some clocks after a test clock fall
  a_fall_only: assert property ($changed({o_tdo, o_tdo_oe_n, o_tap_state})
    |-> !i_tck && !$past(i_tck, 3)) else $error("output moved off tck fall");
  a_select_leaves: assert property ($rose(o_tap_state[9])
    |-> ##[14:18] (o_tap_state[10] || o_tap_state[0])) else $error("select state held");
  a_ir_update: assert property ($changed(o_instruction)
    |-> o_tap_state[15] || o_tap_state[0]) else $error("instruction moved off update");
  a_latch_update: assert property ($changed(o_chain_latch) |-> $rose(o_tap_state[8]))
    else $error("chain latch moved off update");
  a_ctrl_update: assert property ($changed(o_test_control)
    |-> $rose(o_tap_state[8]) || o_tap_state[0]) else $error("control moved off update");
  a_run_idle: assert property (o_run_test |-> o_tap_state[1] || $past(o_tap_state[1]))
    else $error("run test outside idle");
  a_mode_update: assert property ($changed({o_test_mode, o_outputs_highz})
    |-> o_tap_state[15] || o_tap_state[0]) else $error("mode moved off update");
endmodule // bsttap_monitor

bind bsttap_controller bsttap_monitor #(.CHAIN_W(CHAIN_W)) i_bsttap_monitor (.i_clk(i_clk),
  .i_reset(i_reset), .i_tck(i_tck), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n),
  .o_chain_latch(o_chain_latch), .o_test_control(o_test_control),
  .o_instruction(o_instruction), .o_test_mode(o_test_mode),
  .o_outputs_highz(o_outputs_highz), .o_run_test(o_run_test), .o_tap_state(o_tap_state));

// *** verification/bsttap_tester.sv ***
`timescale 1ns/1ps
module bsttap_tester (
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_n,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  logic tdo_line;
  // Pull-up wins whenever the device floats its serial output
  assign tdo_line = i_tdo_oe_n ? 1'b1 : i_tdo;
  // Clock parked low between frames so no false edge at reset release
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // One 160 ns period; mode and data set 40 ns before the rise and held 120 ns after it
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #40;
    tdo = tdo_line;
    o_tck = 1'b1;
    #80;
    o_tck = 1'b0;
    #40;
  endtask
endmodule // bsttap_tester

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        i_clk, i_reset, tck, tms, tdi, tdo, oe_n, t_mode, hiz, run, b;
  logic [17:0] pins, latch, d, lat_m, w;
  logic [1:0]  ctl;
  logic [7:0]  ir, op;
  logic [15:0] st;
  logic [6:0]  ops [18] = '{7'h00, 7'h02, 7'h03, 7'h06, 7'h07, 7'h09, 7'h0A, 7'h0B, 7'h0C,
                            7'h0D, 7'h0E, 7'h0F, 7'h01, 7'h04, 7'h05, 7'h08, 7'h10, 7'h7F};
  integer      n_mismatch = 0, cmp_count = 0, seed = 60, cyc = 0, ctl_m, i, n;
  bsttap_controller #(.CHAIN_W(18)) i_bsttap_controller (.i_clk(i_clk), .i_reset(i_reset),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_pin_sample(pins), .o_tdo(tdo), .o_tdo_oe_n(oe_n),
    .o_chain_latch(latch), .o_test_control(ctl), .o_instruction(ir), .o_test_mode(t_mode),
    .o_outputs_highz(hiz), .o_run_test(run), .o_tap_state(st));
  bsttap_tester i_bsttap_tester (.i_tdo(tdo), .i_tdo_oe_n(oe_n), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Hang guard, well above the roughly 12.6k cycles the sequence needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic st1(input logic m, input logic v);
    i_bsttap_tester.step(m, v, b);
  endtask
  // Full scan from idle back to idle; p > 0 parks in pause after bit p
  task automatic scan(input logic is_ir, input integer len, input logic [17:0] din,
                      input integer p);
    integer k, j;
    st1(1, 0);
    if (is_ir) st1(1, 0);
    st1(0, 0);
    st1(0, 0);
    for (k = 0; k < len; k++) begin
      st1(k == len - 1 || k == p - 1, din[k]);
      d[k] = b;
      if (k == p - 1) for (j = 0; j < 4; j++) st1(j == 2, 0);
    end
    st1(1, 0);
    st1(0, 0);
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Every opcode family, each followed by a worst-case return to reset from shift
  initial begin
    i_reset = 1'b1;
    pins = 18'h00000;
    lat_m = 18'h00000;
    ctl_m = 2;
    repeat (12) @(posedge i_clk);
    #1 i_reset = 1'b0;
    chk("state", 16'h0001, st);
    chk("instruction", 8'hFF, ir);
    chk("control", 2'h2, ctl);
    for (i = 0; i < 18; i++) begin
      op = {1'($random(seed)), ops[i]};
      st1(0, 0);
      scan(1, 8, op, 3);
      chk("ir capture", 8'h81, d[7:0]);
      chk("instruction", op, ir);
      chk("test mode", ops[i] inside {0, 3, 6, 7, 9, 11, 13, 15}, t_mode);
      chk("highz", ops[i] == 6, hiz);
      pins = $random(seed);
      w = $random(seed);
      n = (ops[i] inside {0, 2, 3, 10, 11, 12}) ? 18 : (ops[i] inside {14, 15}) ? 2 : 1;
      scan(0, n == 1 ? 4 : n, w, n == 18 ? 5 : 0);
      if (n == 1) chk("bypass", {w[2:0], 1'b0}, d[3:0]);
      if (n == 18) begin
        chk("chain out", ops[i] inside {10, 11} ? lat_m : pins, d);
        if (!(ops[i] inside {10, 11})) lat_m = w;
        chk("chain latch", lat_m, latch);
      end
      if (n == 2) begin
        chk("control out", ctl_m, d[1:0]);
        ctl_m = w[1:0];
        chk("control", ctl_m, ctl);
      end
      chk("run test", ops[i] == 9, run);
      for (n = 0; n < 9; n++) st1(n < 2 || n > 3, 0);
      chk("state", 16'h0001, st);
      chk("instruction", 8'hFF, ir);
      ctl_m = 2;
      chk("control", ctl_m, ctl);
      chk("chain latch", lat_m, latch);
    end
    // Mid-run reset while a test-mode instruction is live
    st1(0, 0);
    scan(1, 8, 8'h00, 0);
    chk("test mode", 1'b1, t_mode);
    @(posedge i_clk);
    #1 i_reset = 1'b1;
    repeat (3) @(posedge i_clk);
    #1 i_reset = 1'b0;
    chk("state", 16'h0001, st);
    chk("instruction", 8'hFF, ir);
    chk("test mode", 1'b0, t_mode);
    chk("chain latch", 18'h00000, latch);
    tally_and_finish;
  end
endmodule // tb
